// file: design/qdac_pkg.sv
// shared constants, carrier types and helpers for the quad converter serial target port
// assumes a single 10 MHz clock domain; link pins are synchronised inside the port

package qdac_pkg;
   localparam int NCH = 4;
   localparam int CODE_W = 10;
   localparam int PAD_W = 6;
   localparam int BYTE_W = 8;
   localparam int PD_BITS = 2;
   localparam int PD_W = NCH * PD_BITS;
   localparam int FIFO_DEPTH = 16;

   localparam logic [4:0] ADDR_FIXED = 5'h03;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [3:0] TX_LAST_BIT = 4'h7;
   localparam logic [1:0] BYTE_ADDR = 2'h0;
   localparam logic [1:0] BYTE_CMD = 2'h1;
   localparam logic [1:0] BYTE_LAST = 2'h3;
   localparam logic [1:0] CHAN_A = 2'h0;
   localparam logic [1:0] CHAN_D = 2'h3;

   localparam logic [3:0] CMD_WRITE_IN = 4'h1;
   localparam logic [3:0] CMD_UPDATE = 4'h2;
   localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
   localparam logic [3:0] CMD_POWER = 4'h4;

   localparam logic [1:0] PD_NORMAL = 2'h0;
   localparam logic [1:0] PD_1K = 2'h1;
   localparam logic [1:0] PD_100K = 2'h2;
   localparam logic [1:0] PD_TRISTATE = 2'h3;

   localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
   localparam logic [PD_W-1:0] PD_RESET = 8'h00;

   // one received command word, in wire order
   typedef struct packed {
      logic [3:0] cmd;
      logic [NCH-1:0] chan_sel;
      logic [CODE_W-1:0] code;
      logic [PAD_W-1:0] pad;
   } qdac_word_t;

   typedef logic [NCH-1:0][CODE_W-1:0] qdac_codes_t;

   typedef enum logic [2:0] {
      QDAC_IDLE,
      QDAC_RX,
      QDAC_RX_ACK,
      QDAC_TX,
      QDAC_TX_ACK,
      QDAC_IGNORE
   } qdac_link_st_t;

   // single selected channel, otherwise channel a
   function automatic logic [1:0] qdac_chan_of(input logic [NCH-1:0] sel);
      logic [1:0] r;
      r = CHAN_A;
      if ($onehot(sel)) begin
         for (int i = 0; i < NCH; i++) begin
            if (sel[i]) begin
               r = 2'(i);
            end
         end
      end
      return r;
   endfunction
endpackage

// file: design/qdac_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock; width and depth shape the storage, depth a power of two
`timescale 1ns/1ps
`default_nettype none

module qdac_fifo #(
   parameter int W = 24,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic [AW:0] next_wr_ptr;
   logic [AW:0] next_rd_ptr;
   logic [AW:0] count;

   assign count = wr_ptr - rd_ptr;
   assign in_ready = (count != FULL_CNT);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr[AW-1:0]];

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (in_valid && in_ready) begin
         next_wr_ptr = wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
         next_rd_ptr = rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // storage needs no reset; only entries behind the write pointer are read
   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule

`default_nettype wire

// file: design/qdac_i2c_port.sv
// two-wire target port and channel register bank of a quad 10-bit converter
// assumes scl, sda, strap and load pins are asynchronous to clk; clk >= 8x scl
`timescale 1ns/1ps
`default_nettype none

module qdac_i2c_port (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_strap_high_bit,
   input wire logic addr_strap_low_bit,
   input wire logic load_outputs_n,
   input wire logic updates_hold,
   output qdac_pkg::qdac_codes_t dac_out_code,
   output logic [qdac_pkg::PD_W-1:0] channel_power_mode_select,
   output logic [qdac_pkg::NCH-1:0] chan_powered_down
);
   // ---------------------------------------------------------------
   // pin synchronisers and edge detection
   // ---------------------------------------------------------------
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic [1:0] load_outputs_n_sync;
   logic [1:0] strap_hi_sync;
   logic [1:0] strap_lo_sync;
   logic scl_q;
   logic sda_q;
   logic load_outputs_n_q;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic load_outputs_n_fall;
   logic [6:0] my_addr;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         load_outputs_n_sync <= 2'h3;
         strap_hi_sync <= 2'h0;
         strap_lo_sync <= 2'h0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         load_outputs_n_q <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         load_outputs_n_sync <= {load_outputs_n_sync[0], load_outputs_n};
         strap_hi_sync <= {strap_hi_sync[0], addr_strap_high_bit};
         strap_lo_sync <= {strap_lo_sync[0], addr_strap_low_bit};
         scl_q <= scl_sync[1];
         sda_q <= sda_sync[1];
         load_outputs_n_q <= load_outputs_n_sync[1];
      end
   end

   assign scl = scl_sync[1];
   assign sda = sda_sync[1];
   assign scl_rise = scl && !scl_q;
   assign scl_fall = !scl && scl_q;
   assign start_det = scl && scl_q && sda_q && !sda;
   assign stop_det = scl && scl_q && !sda_q && sda;
   assign load_outputs_n_fall = load_outputs_n_q && !load_outputs_n_sync[1];
   // fixed high bits keep address zero out, so general call never matches
   assign my_addr = {qdac_pkg::ADDR_FIXED, strap_hi_sync[1], strap_lo_sync[1]};

   // ---------------------------------------------------------------
   // command word buffer
   // ---------------------------------------------------------------
   qdac_pkg::qdac_word_t push_data;
   qdac_pkg::qdac_word_t fifo_out_data;
   logic push_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic pop;

   qdac_fifo #(
      .W($bits(qdac_pkg::qdac_word_t)),
      .DEPTH(qdac_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(push_valid),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // a load pin edge takes the bank for one cycle, so the drain waits
   assign fifo_out_ready = !updates_hold && !load_outputs_n_fall;
   assign pop = fifo_out_valid && fifo_out_ready;

   // ---------------------------------------------------------------
   // link state machine
   // ---------------------------------------------------------------
   qdac_pkg::qdac_link_st_t st, next_st;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [1:0] byte_idx, next_byte_idx;
   logic [7:0] rx_shift, next_rx_shift;
   logic [15:0] word_acc, next_word_acc;
   logic [7:0] tx_shift, next_tx_shift;
   logic [1:0] rd_ptr, next_rd_ptr;
   logic rw, next_rw;
   logic tx_lo, next_tx_lo;
   logic nack, next_nack;
   logic next_sda_oe;
   logic next_push_valid;
   qdac_pkg::qdac_word_t next_push_data;
   qdac_pkg::qdac_codes_t in_code;

   function automatic logic [7:0] tx_byte(input qdac_pkg::qdac_codes_t c, input logic [1:0] p,
                                          input logic lo);
      logic [2*qdac_pkg::BYTE_W-1:0] d;
      d = {c[p], qdac_pkg::PAD_W'(0)};
      return lo ? d[qdac_pkg::BYTE_W-1:0] : d[2*qdac_pkg::BYTE_W-1:qdac_pkg::BYTE_W];
   endfunction

   always_comb begin
      logic lo_n;
      logic [1:0] ptr_n;
      lo_n = !tx_lo;
      ptr_n = tx_lo ? rd_ptr + 1'b1 : rd_ptr;
      next_st = st;
      next_bit_cnt = bit_cnt;
      next_byte_idx = byte_idx;
      next_rx_shift = rx_shift;
      next_word_acc = word_acc;
      next_tx_shift = tx_shift;
      next_rd_ptr = rd_ptr;
      next_rw = rw;
      next_tx_lo = tx_lo;
      next_nack = nack;
      next_sda_oe = sda_oe;
      next_push_valid = 1'b0;
      next_push_data = push_data;
      if (stop_det) begin
         // partial words are simply never pushed
         next_st = qdac_pkg::QDAC_IDLE;
         next_sda_oe = 1'b0;
      end else if (start_det) begin
         next_st = qdac_pkg::QDAC_RX;
         next_bit_cnt = '0;
         next_byte_idx = qdac_pkg::BYTE_ADDR;
         next_sda_oe = 1'b0;
      end else begin
         unique case (st)
            qdac_pkg::QDAC_IDLE, qdac_pkg::QDAC_IGNORE: begin
            end
            qdac_pkg::QDAC_RX: begin
               if (scl_rise) begin
                  next_rx_shift = {rx_shift[6:0], sda};
                  next_bit_cnt = bit_cnt + 1'b1;
               end else if (scl_fall && bit_cnt == qdac_pkg::BIT_LAST) begin
                  next_st = qdac_pkg::QDAC_RX_ACK;
                  next_bit_cnt = '0;
                  if (byte_idx == qdac_pkg::BYTE_ADDR) begin
                     if (rx_shift[7:1] == my_addr) begin
                        next_sda_oe = 1'b1;
                        next_rw = rx_shift[0];
                     end else begin
                        next_st = qdac_pkg::QDAC_IGNORE;
                     end
                  end else begin
                     next_word_acc = {word_acc[7:0], rx_shift};
                     if (byte_idx == qdac_pkg::BYTE_CMD) begin
                        next_rd_ptr = qdac_pkg::qdac_chan_of(rx_shift[3:0]);
                     end
                     if (byte_idx == qdac_pkg::BYTE_LAST) begin
                        // a full buffer refuses the word with a nack
                        next_sda_oe = fifo_in_ready;
                        next_push_valid = fifo_in_ready;
                        next_push_data = {word_acc, rx_shift};
                     end else begin
                        next_sda_oe = 1'b1;
                     end
                  end
               end
            end
            qdac_pkg::QDAC_RX_ACK: begin
               if (scl_fall) begin
                  next_sda_oe = 1'b0;
                  if (byte_idx == qdac_pkg::BYTE_ADDR && rw) begin
                     next_st = qdac_pkg::QDAC_TX;
                     next_tx_lo = 1'b0;
                     next_tx_shift = tx_byte(in_code, rd_ptr, 1'b0);
                     next_sda_oe = !next_tx_shift[7];
                  end else if (byte_idx == qdac_pkg::BYTE_LAST) begin
                     next_st = qdac_pkg::QDAC_IGNORE;
                  end else begin
                     next_st = qdac_pkg::QDAC_RX;
                     next_byte_idx = byte_idx + 1'b1;
                  end
               end
            end
            qdac_pkg::QDAC_TX: begin
               if (scl_fall) begin
                  if (bit_cnt == qdac_pkg::TX_LAST_BIT) begin
                     next_sda_oe = 1'b0;
                     next_st = qdac_pkg::QDAC_TX_ACK;
                     next_bit_cnt = '0;
                  end else begin
                     next_tx_shift = {tx_shift[6:0], 1'b0};
                     next_sda_oe = !tx_shift[6];
                     next_bit_cnt = bit_cnt + 1'b1;
                  end
               end
            end
            qdac_pkg::QDAC_TX_ACK: begin
               if (scl_rise) begin
                  next_nack = sda;
               end else if (scl_fall) begin
                  if (nack) begin
                     next_st = qdac_pkg::QDAC_IGNORE;
                  end else begin
                     next_st = qdac_pkg::QDAC_TX;
                     next_tx_lo = lo_n;
                     next_rd_ptr = ptr_n;
                     next_tx_shift = tx_byte(in_code, ptr_n, lo_n);
                     next_sda_oe = !next_tx_shift[7];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= qdac_pkg::QDAC_IDLE;
         bit_cnt <= '0;
         byte_idx <= qdac_pkg::BYTE_ADDR;
         rx_shift <= '0;
         word_acc <= '0;
         tx_shift <= '0;
         rd_ptr <= qdac_pkg::CHAN_A;
         rw <= 1'b0;
         tx_lo <= 1'b0;
         nack <= 1'b0;
         sda_oe <= 1'b0;
         push_valid <= 1'b0;
         push_data <= '0;
      end else begin
         st <= next_st;
         bit_cnt <= next_bit_cnt;
         byte_idx <= next_byte_idx;
         rx_shift <= next_rx_shift;
         word_acc <= next_word_acc;
         tx_shift <= next_tx_shift;
         rd_ptr <= next_rd_ptr;
         rw <= next_rw;
         tx_lo <= next_tx_lo;
         nack <= next_nack;
         sda_oe <= next_sda_oe;
         push_valid <= next_push_valid;
         push_data <= next_push_data;
      end
   end

   // open drain: only ever pulls low
   assign sda_out = 1'b0;

   // ---------------------------------------------------------------
   // channel register bank
   // ---------------------------------------------------------------
   qdac_pkg::qdac_codes_t next_in_code, next_out_code;
   logic [qdac_pkg::PD_W-1:0] next_pd;

   always_comb begin
      next_in_code = in_code;
      next_out_code = dac_out_code;
      next_pd = channel_power_mode_select;
      if (load_outputs_n_fall) begin
         next_out_code = in_code;
      end
      if (pop) begin
         unique case (fifo_out_data.cmd)
            qdac_pkg::CMD_WRITE_IN, qdac_pkg::CMD_WRITE_UPD: begin
               for (int i = 0; i < qdac_pkg::NCH; i++) begin
                  if (fifo_out_data.chan_sel[i]) begin
                     next_in_code[i] = fifo_out_data.code;
                     if (!load_outputs_n_sync[1] || fifo_out_data.cmd == qdac_pkg::CMD_WRITE_UPD) begin
                        next_out_code[i] = fifo_out_data.code;
                     end
                  end
               end
            end
            qdac_pkg::CMD_UPDATE: begin
               for (int i = 0; i < qdac_pkg::NCH; i++) begin
                  if (fifo_out_data.chan_sel[i]) begin
                     next_out_code[i] = in_code[i];
                  end
               end
            end
            qdac_pkg::CMD_POWER: begin
               // channel bits ignored; output registers left alone
               next_pd = qdac_pkg::PD_W'({fifo_out_data.code, fifo_out_data.pad});
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         in_code <= {qdac_pkg::NCH{qdac_pkg::CODE_RESET}};
         dac_out_code <= {qdac_pkg::NCH{qdac_pkg::CODE_RESET}};
         channel_power_mode_select <= qdac_pkg::PD_RESET;
      end else begin
         in_code <= next_in_code;
         dac_out_code <= next_out_code;
         channel_power_mode_select <= next_pd;
      end
   end

   for (genvar g = 0; g < qdac_pkg::NCH; g++) begin : g_pd
      assign chan_powered_down[g] =
         channel_power_mode_select[g*qdac_pkg::PD_BITS +: qdac_pkg::PD_BITS] != qdac_pkg::PD_NORMAL;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_addr_ack: assert property ((st == qdac_pkg::QDAC_RX && scl_fall && bit_cnt == qdac_pkg::BIT_LAST
      && byte_idx == qdac_pkg::BYTE_ADDR && rx_shift[7:1] == my_addr) |=> sda_oe)
      else $error("matched address not acknowledged");
   a_ignore_quiet: assert property ((st == qdac_pkg::QDAC_IGNORE) |-> !sda_oe)
      else $error("unselected port drives data line");
   a_byte_bits: assert property ((st == qdac_pkg::QDAC_RX) |-> bit_cnt <= qdac_pkg::BIT_LAST)
      else $error("receive bit count overran a byte");
   a_sda_stable_high: assert property ((scl && scl_q && !start_det && !stop_det) |=>
      sda_oe == $past(sda_oe))
      else $error("data line changed while clock high");
   a_data_ack: assert property ((st == qdac_pkg::QDAC_RX && scl_fall && bit_cnt == qdac_pkg::BIT_LAST
      && (byte_idx == qdac_pkg::BYTE_CMD || byte_idx == 2'(qdac_pkg::BYTE_CMD + 1'b1))) |=> sda_oe)
      else $error("write byte not acknowledged");
   a_rd_wrap: assert property ((st == qdac_pkg::QDAC_TX_ACK && scl_fall && !nack && tx_lo
      && rd_ptr == qdac_pkg::CHAN_D) |=> rd_ptr == qdac_pkg::CHAN_A)
      else $error("readback did not wrap to channel a");
   a_pd_load: assert property ((pop && fifo_out_data.cmd == qdac_pkg::CMD_POWER) |=>
      channel_power_mode_select == $past(qdac_pkg::PD_W'({fifo_out_data.code, fifo_out_data.pad})))
      else $error("power mode not loaded from low byte");
   a_pd_keeps_out: assert property ((pop && fifo_out_data.cmd == qdac_pkg::CMD_POWER && !load_outputs_n_fall)
      |=> $stable(dac_out_code))
      else $error("power command changed output registers");
   a_load_outputs_n_low_write: assert property ((pop && fifo_out_data.cmd == qdac_pkg::CMD_WRITE_IN
      && fifo_out_data.chan_sel[0] && !load_outputs_n_sync[1]) |=> dac_out_code[0] == $past(fifo_out_data.code))
      else $error("transparent write missed output register");
   a_load_outputs_n_fall_copy: assert property (load_outputs_n_fall |=> dac_out_code == $past(in_code))
      else $error("load edge did not copy input registers");
   a_push_full_word: assert property (push_valid |-> $past(byte_idx) == qdac_pkg::BYTE_LAST
      && $past(st) == qdac_pkg::QDAC_RX)
      else $error("partial word pushed");

   c_write_word: cover property (pop && fifo_out_data.cmd == qdac_pkg::CMD_WRITE_IN);
   c_power_cmd: cover property (pop && fifo_out_data.cmd == qdac_pkg::CMD_POWER);
   c_read_wrap: cover property (st == qdac_pkg::QDAC_TX_ACK && scl_fall && tx_lo
      && rd_ptr == qdac_pkg::CHAN_D);
   c_fifo_full: cover property (!fifo_in_ready);
endmodule

`default_nettype wire

// file: tb/qdac_bus_master.sv
// behavioural two-wire bus controller driving the target port
// assumes an external pull-up: sda_pull high means the line is held low
`timescale 1ns/1ps
`default_nettype none

module qdac_bus_master (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_pull
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // ------------------------------------------------------------
   // bit, byte and framing tasks, 800 ns per bit
   // ------------------------------------------------------------
   task automatic bit_x(input logic b, output logic r);
      #100 sda_pull = ~b;
      #300 scl = 1'b1;
      #200 r = sda;
      #200 scl = 1'b0;
   endtask

   task automatic start_c();
      @(posedge clk);
      #1 sda_pull = 1'b0;
      #200 scl = 1'b1;
      #400 sda_pull = 1'b1;
      #400 scl = 1'b0;
   endtask

   task automatic stop_c();
      #100 sda_pull = 1'b1;
      #300 scl = 1'b1;
      #400 sda_pull = 1'b0;
      #400;
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'b1, r);
      ack = ~r;
   endtask

   // last byte of a read is not acknowledged
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, d[i]);
      end
      bit_x(last, r);
   endtask
endmodule
`default_nettype wire

// file: tb/qdac_i2c_port_tb.sv
// self-checking bench for the quad converter serial target port
// assumes the bus controller model in qdac_bus_master.sv
`timescale 1ns/1ps
`default_nettype none

module qdac_i2c_port_tb;
   logic clk, rst_b, sda_out, sda_oe, m_pull, scl, hi_s, lo_s, load_n, hold;
   wire logic sda;
   qdac_pkg::qdac_codes_t out;
   logic [7:0] pdsel;
   logic [3:0] pdn;
   int fails = 0;
   int samples_checked = 0;
   logic a;
   logic [7:0] d;
   logic [7:0] exp_rb [6] = '{8'h55, 8'h40, 8'hff, 8'hc0, 8'h55, 8'h40};
   // open drain with pull-up
   assign sda = ~(sda_oe & ~sda_out) & ~m_pull;

   qdac_i2c_port u_dut (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_high_bit(hi_s),
      .addr_strap_low_bit(lo_s), .load_outputs_n(load_n), .updates_hold(hold),
      .dac_out_code(out), .channel_power_mode_select(pdsel), .chan_powered_down(pdn));
   qdac_bus_master u_m (.clk(clk), .sda(sda), .scl(scl), .sda_pull(m_pull));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l,
         output logic a3);
      logic k;
      u_m.start_c();
      u_m.wbyte(8'h1c, k);
      check(16'(k), 16'h1);
      u_m.wbyte(c, k);
      check(16'(k), 16'h1);
      u_m.wbyte(h, k);
      check(16'(k), 16'h1);
      u_m.wbyte(l, a3);
      u_m.stop_c();
      repeat (10) @(posedge clk);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_addr();
      logic [7:0] bad [3] = '{8'h18, 8'h00, 8'h1e};
      for (int i = 0; i < 3; i++) begin
         u_m.start_c();
         u_m.wbyte(bad[i], a);
         check(16'(a), 16'h0);
         u_m.wbyte(8'h11, a);
         check(16'(a), 16'h0);
         u_m.stop_c();
      end
      check(16'(pdsel), 16'h0);
   endtask

   task automatic t_write();
      wr(8'h11, 8'hff, 8'hc0, a);
      check(16'(a), 16'h1);
      check(16'(out[0]), 16'h3ff);
      check(16'(out[1]), 16'h0);
      #1 load_n = 1'b1;
      wr(8'h1e, 8'h55, 8'h40, a);
      check(16'(out[3]), 16'h0);
      wr(8'h28, 8'h00, 8'h00, a);
      check(16'(out[3]), 16'h155);
      check(16'(out[2]), 16'h0);
      for (int j = 0; j < 2; j++) begin
         u_m.start_c();
         u_m.wbyte(8'h1c, a);
         u_m.wbyte(j == 0 ? 8'h08 : 8'h0f, a);
         u_m.start_c();
         u_m.wbyte(8'h1d, a);
         check(16'(a), 16'h1);
         for (int i = 2 * j; i < 4 + j * 2; i++) begin
            u_m.rbyte(i == 3 + j * 2, d);
            check(16'(d), 16'(exp_rb[i]));
         end
         u_m.stop_c();
      end
      load_n = 1'b0;
      repeat (8) @(posedge clk);
      check(16'(out[2]), 16'h155);
      check(16'(out[0]), 16'h3ff);
   endtask

   task automatic t_power();
      wr(8'h40, 8'haa, 8'he4, a);
      check(16'(pdsel), 16'he4);
      check(16'(pdn), 16'he);
      check(16'(out[1]), 16'h155);
      wr(8'h32, 8'h00, 8'h40, a);
      check(16'(out[1]), 16'h1);
      u_m.start_c();
      u_m.wbyte(8'h1c, a);
      u_m.wbyte(8'h31, a);
      u_m.wbyte(8'h00, a);
      u_m.stop_c();
      repeat (10) @(posedge clk);
      check(16'(out[0]), 16'h3ff);
   endtask

   // stalled drain: sixteen words fit, the next one is refused
   task automatic t_fifo();
      #1 hold = 1'b1;
      for (int i = 0; i < 17; i++) begin
         wr(8'h31, 8'(i), 8'h00, a);
         check(16'(a), 16'(i < 16));
      end
      #1 hold = 1'b0;
      repeat (40) @(posedge clk);
      check(16'(out[0]), 16'h3c);
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      rst_b = 1'b0;
      hi_s = 1'b1;
      lo_s = 1'b0;
      load_n = 1'b0;
      hold = 1'b0;
      repeat (12) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (8) @(posedge clk);
      t_addr();
      t_write();
      t_power();
      t_fifo();
      end_sim();
   end

   initial begin
      #3000000;
      fails++;
      end_sim();
   end
endmodule
`default_nettype wire
